// *** lfd_regs.svh ***
// Register offsets, reset values, field positions and timing counts of the
// flash driver register slave. Included by its bare name.
`ifndef LFD_REGS_SVH
`define LFD_REGS_SVH
`define LFD_OFF_CHIP_ID      8'h00
`define LFD_OFF_ENABLE       8'h01
`define LFD_OFF_DROOP        8'h02
`define LFD_OFF_FL1          8'h03
`define LFD_OFF_FL2          8'h04
`define LFD_OFF_TO1          8'h05
`define LFD_OFF_TO2          8'h06
`define LFD_OFF_CONV         8'h07
`define LFD_OFF_TIMING       8'h08
`define LFD_OFF_THERM        8'h09
`define LFD_OFF_FAULT_FLAGS_PRIMARY       8'h0a
`define LFD_OFF_FLAGS2       8'h0b
`define LFD_OFF_PART         8'h0c
`define LFD_OFF_LAST         8'h0d
`define LFD_OFF_IND          8'h39
`define LFD_RST_ENABLE       8'h80
`define LFD_RST_DROOP        8'h01
`define LFD_RST_FL1          8'hbf
`define LFD_RST_FL2          8'h3f
`define LFD_RST_TO1          8'hbf
`define LFD_RST_TO2          8'h3f
`define LFD_RST_CONV         8'h09
`define LFD_RST_TIMING       8'h1a
`define LFD_RST_THERM        8'h08
`define LFD_RST_IND          8'h7f
`define LFD_BIT_STROBE_TYPE  6
`define LFD_BIT_OVERRIDE     7
`define LFD_POS_MODE         2
// Host register offsets on AXI4-Lite.
`define LFD_H_CTRL           8'h00
`define LFD_H_ADDR           8'h04
`define LFD_H_WDATA          8'h08
`define LFD_H_RDATA          8'h0c
`define LFD_H_STATUS         8'h10
`define LFD_H_IRQ_STAT       8'h14
`define LFD_H_IRQ_MASK       8'h18
`define LFD_H_DIV            8'h1c
`define LFD_RST_DIV          8'h05
`endif

// *** lfd_pkg.sv ***
// Types shared by both ends of the flash driver serial link.
// Assumes the constants header is included where offsets are needed.
package lfd_pkg;
	typedef enum logic [1:0] {
		LFD_MODE_STANDBY,
		LFD_MODE_INFRARED,
		LFD_MODE_TORCH,
		LFD_MODE_FLASH
	} lfd_mode_t;
	typedef logic [7:0] lfd_byte_t;
endpackage

// *** lfd_link_if.sv ***
// Two-wire link between the controller and the flash driver target.
// Resolves open-drain levels from the enables; pull-ups are implied.
`timescale 1ns/1ps
interface lfd_link_if;
	logic scl_oe;
	logic sda_host_oe;
	logic sda_dev_oe;
	logic scl;
	logic sda;
	assign scl = ~scl_oe;
	assign sda = ~(sda_host_oe | sda_dev_oe);
	modport host (output scl_oe, output sda_host_oe, input scl, input sda);
	modport dev (output sda_dev_oe, input scl, input sda);
endinterface

// *** lfd_sync.sv ***
// Two flip-flop synchroniser for the serial lines.
// Assumes inputs come from outside the CORE_CLK domain.
`timescale 1ns/1ps
module lfd_sync #(
	parameter int W = 2
) (
	input  wire logic         CORE_CLK,
	input  wire logic         RST_N,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			meta_ff <= '1;
			q       <= '1;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule

// *** lfd_target.sv ***
// Flash driver target: two-wire slave and its register map.
// Assumes the link lines idle high and CORE_CLK samples SCL many times.
`timescale 1ns/1ps
`include "lfd_regs.svh"
module lfd_target
	import lfd_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR  = 7'h63,
	parameter logic [7:0] CHIP_CODE = 8'h5a,  // Arbitrary identity value.
	parameter logic [7:0] PART_CODE = 8'h21   // Arbitrary identity value.
) (
	input  wire logic      CORE_CLK,
	input  wire logic      RST_N,
	lfd_link_if.dev        LINK,
	input  wire lfd_byte_t FAULT1_SET,
	input  wire lfd_byte_t FAULT2_SET,
	input  wire lfd_byte_t LAST_LEVEL,
	output lfd_mode_t      MODE,
	output logic           STROBE_EDGE,
	output lfd_byte_t      SECOND_FLASH_LEVEL,
	output lfd_byte_t      SECOND_TORCH_LEVEL
);
	import lfd_pkg::*;
	typedef enum {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_WAIT} lfd_st_t;
	lfd_st_t    st_ff;
	logic [1:0] ln;
	logic       scl_d_ff, sda_d_ff;
	logic [2:0] cnt_ff;
	lfd_byte_t  sh_ff, ptr_ff;
	logic [1:0] byte_ff;
	logic       rd_ff, oe_ff, ack_ff;
	lfd_byte_t  regs_ff [0:15];
	lfd_byte_t  ind_ff, fl1_ff, fl2_ff;
	lfd_sync #(.W(2)) u_sync (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
		.d({LINK.scl, LINK.sda}), .q(ln));
	wire scl = ln[1];
	wire sda = ln[0];
	wire scl_rise = scl & ~scl_d_ff;
	wire scl_fall = ~scl & scl_d_ff;
	wire start_c  = scl & scl_d_ff & sda_d_ff & ~sda;
	wire stop_c   = scl & scl_d_ff & ~sda_d_ff & sda;
	wire busy     = st_ff != ST_IDLE && st_ff != ST_WAIT;
	wire [7:0] rx_byte = {sh_ff[6:0], sda};
	wire addr_hit = rx_byte[7:1] == DEV_ADDR;
	function automatic lfd_byte_t rd_reg(input lfd_byte_t a);
		if (a == `LFD_OFF_CHIP_ID)
			return CHIP_CODE;
		else if (a == `LFD_OFF_PART)
			return PART_CODE;
		else if (a == `LFD_OFF_FAULT_FLAGS_PRIMARY)
			return fl1_ff;
		else if (a == `LFD_OFF_FLAGS2)
			return fl2_ff;
		else if (a == `LFD_OFF_LAST)
			return LAST_LEVEL;
		else if (a == `LFD_OFF_IND)
			return ind_ff;
		else if (a < 8'h10)
			return regs_ff[a[3:0]];
		return 8'h00;
	endfunction
	wire writable = (ptr_ff >= `LFD_OFF_ENABLE && ptr_ff <= `LFD_OFF_THERM)
		|| ptr_ff == `LFD_OFF_IND;
	wire do_write = st_ff == ST_RX && scl_rise && cnt_ff == 3'd7 &&
		!rd_ff && byte_ff == 2'd2;
	wire lfd_byte_t rd_now = rd_reg(ptr_ff);
	wire clr1_last = st_ff == ST_MACK && scl_rise &&
		ptr_ff == `LFD_OFF_FAULT_FLAGS_PRIMARY;
	wire clr2_last = st_ff == ST_MACK && scl_rise &&
		ptr_ff == `LFD_OFF_FLAGS2;
	assign LINK.sda_dev_oe = oe_ff;
	assign MODE = lfd_mode_t'(regs_ff[1][`LFD_POS_MODE +: 2]);
	assign STROBE_EDGE = regs_ff[1][`LFD_BIT_STROBE_TYPE];
	assign SECOND_FLASH_LEVEL = regs_ff[3][`LFD_BIT_OVERRIDE] ?
		{1'b0, regs_ff[3][6:0]} : regs_ff[4];
	assign SECOND_TORCH_LEVEL = regs_ff[5][`LFD_BIT_OVERRIDE] ?
		{1'b0, regs_ff[5][6:0]} : regs_ff[6];
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			scl_d_ff <= 1'b1;
			sda_d_ff <= 1'b1;
		end else begin
			scl_d_ff <= scl;
			sda_d_ff <= sda;
		end
	end
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			for (int i = 0; i < 16; i++)
				regs_ff[i] <= 8'h00;
			regs_ff[1] <= `LFD_RST_ENABLE;
			regs_ff[2] <= `LFD_RST_DROOP;
			regs_ff[3] <= `LFD_RST_FL1;
			regs_ff[4] <= `LFD_RST_FL2;
			regs_ff[5] <= `LFD_RST_TO1;
			regs_ff[6] <= `LFD_RST_TO2;
			regs_ff[7] <= `LFD_RST_CONV;
			regs_ff[8] <= `LFD_RST_TIMING;
			regs_ff[9] <= `LFD_RST_THERM;
			ind_ff     <= `LFD_RST_IND;
		end else if (do_write && writable) begin
			if (ptr_ff == `LFD_OFF_IND)
				ind_ff <= rx_byte;
			else
				regs_ff[ptr_ff[3:0]] <= rx_byte;
		end
	end
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			fl1_ff <= 8'h00;
			fl2_ff <= 8'h00;
		end else begin
			fl1_ff <= (clr1_last ? 8'h00 : fl1_ff) | FAULT1_SET;
			fl2_ff <= (clr2_last ? 8'h00 : fl2_ff) | FAULT2_SET;
		end
	end
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			st_ff   <= ST_IDLE;
			cnt_ff  <= 3'd0;
			sh_ff   <= 8'h00;
			ptr_ff  <= 8'h00;
			byte_ff <= 2'd0;
			rd_ff   <= 1'b0;
			oe_ff   <= 1'b0;
			ack_ff  <= 1'b0;
		end else if (start_c) begin
			st_ff   <= ST_RX;
			cnt_ff  <= 3'd0;
			byte_ff <= 2'd0;
			rd_ff   <= 1'b0;
			oe_ff   <= 1'b0;
		end else if (stop_c) begin
			st_ff <= ST_IDLE;
			oe_ff <= 1'b0;
		end else if (busy && scl && scl_d_ff && sda != sda_d_ff) begin
			st_ff <= ST_WAIT;
			oe_ff <= 1'b0;
		end else begin
			unique case (st_ff)
				ST_IDLE, ST_WAIT: begin
					oe_ff <= 1'b0;
				end
				ST_RX: begin
					if (scl_rise) begin
						sh_ff  <= rx_byte;
						cnt_ff <= cnt_ff + 3'd1;
						if (cnt_ff == 3'd7) begin
							ack_ff <= byte_ff != 2'd0 || addr_hit;
							if (byte_ff == 2'd0)
								rd_ff <= rx_byte[0];
							else if (byte_ff == 2'd1)
								ptr_ff <= rx_byte;
							st_ff <= ST_ACK;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall && !oe_ff && ack_ff) begin
						oe_ff <= 1'b1;
					end else if (scl_fall && !ack_ff) begin
						st_ff <= ST_WAIT;
					end else if (scl_fall) begin
						if (byte_ff == 2'd2)
							ptr_ff <= ptr_ff + 8'h01;
						if (byte_ff != 2'd2)
							byte_ff <= byte_ff + 2'd1;
						if (rd_ff) begin
							sh_ff  <= rd_now;
							oe_ff  <= ~rd_now[7];
							cnt_ff <= 3'd1;
							st_ff  <= ST_TX;
						end else begin
							oe_ff  <= 1'b0;
							cnt_ff <= 3'd0;
							st_ff  <= ST_RX;
						end
					end
				end
				ST_TX: begin
					if (scl_fall) begin
						if (cnt_ff == 3'd0) begin
							oe_ff  <= 1'b0;
							ack_ff <= 1'b0;
							st_ff  <= ST_MACK;
						end else begin
							oe_ff  <= ~sh_ff[~cnt_ff];
							cnt_ff <= cnt_ff + 3'd1;
						end
					end
				end
				ST_MACK: begin
					if (scl_rise && sda) begin
						st_ff <= ST_WAIT;
					end else if (scl_rise) begin
						ptr_ff <= ptr_ff + 8'h01;
						ack_ff <= 1'b1;
					end else if (scl_fall && ack_ff) begin
						sh_ff  <= rd_now;
						oe_ff  <= ~rd_now[7];
						cnt_ff <= 3'd1;
						ack_ff <= 1'b0;
						st_ff  <= ST_TX;
					end
				end
			endcase
		end
	end
endmodule

// *** lfd_controller.sv ***
// Two-wire controller with AXI4-Lite registers for the flash driver.
// Assumes the target stretches no clock; pull-ups are implied.
`timescale 1ns/1ps
`include "lfd_regs.svh"
module lfd_controller
	import lfd_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h63
) (
	input  wire logic        CORE_CLK,
	input  wire logic        RST_N,
	lfd_link_if.host         LINK,
	input  wire logic [7:0]  S_AXI_AWADDR,
	input  wire logic        S_AXI_AWVALID,
	output logic             S_AXI_AWREADY,
	input  wire logic [31:0] S_AXI_WDATA,
	input  wire logic [3:0]  S_AXI_WSTRB,
	input  wire logic        S_AXI_WVALID,
	output logic             S_AXI_WREADY,
	output logic [1:0]       S_AXI_BRESP,
	output logic             S_AXI_BVALID,
	input  wire logic        S_AXI_BREADY,
	input  wire logic [7:0]  S_AXI_ARADDR,
	input  wire logic        S_AXI_ARVALID,
	output logic             S_AXI_ARREADY,
	output logic [31:0]      S_AXI_RDATA,
	output logic [1:0]       S_AXI_RRESP,
	output logic             S_AXI_RVALID,
	input  wire logic        S_AXI_RREADY,
	output logic             IRQ
);
	import lfd_pkg::*;
	typedef enum {C_IDLE, C_START, C_BIT, C_ACK, C_STOP} lfd_cst_t;
	lfd_cst_t   st_ff;
	logic [1:0] ln;
	logic       aw_ff, w_ff;
	logic [7:0] awa_ff;
	logic [31:0] wd_ff;
	lfd_byte_t  ptr_ff, wdat_ff, rdat_ff, sh_ff;
	logic [7:0] div_ff, dcnt_ff;
	logic [1:0] ph_ff, seq_ff;
	logic [2:0] bit_ff;
	logic       rd_ff, rx_ff, nak_ff, busy_ff, restart_ff;
	logic [1:0] ist_ff, imask_ff;
	lfd_sync #(.W(2)) u_sync (.CORE_CLK(CORE_CLK), .RST_N(RST_N),
		.d({LINK.scl, LINK.sda}), .q(ln));
	wire tick = dcnt_ff == 8'h00;
	wire aw_go = S_AXI_AWVALID && !aw_ff;
	wire w_go = S_AXI_WVALID && !w_ff;
	wire wr_do = aw_ff && w_ff && !S_AXI_BVALID;
	wire go = wr_do && awa_ff == `LFD_H_CTRL && wd_ff[0] && !busy_ff;
	wire done = st_ff == C_STOP && tick && ph_ff == 2'd3;
	assign S_AXI_AWREADY = !aw_ff;
	assign S_AXI_WREADY = !w_ff;
	assign S_AXI_ARREADY = !S_AXI_RVALID;
	assign S_AXI_BRESP = 2'b00;
	assign S_AXI_RRESP = 2'b00;
	assign IRQ = |(ist_ff & imask_ff);
	function automatic logic [31:0] rd_map(input logic [7:0] a);
		unique case (a)
			`LFD_H_ADDR:     return {24'h0, ptr_ff};
			`LFD_H_WDATA:    return {24'h0, wdat_ff};
			`LFD_H_RDATA:    return {24'h0, rdat_ff};
			`LFD_H_STATUS:   return {30'h0, nak_ff, busy_ff};
			`LFD_H_IRQ_STAT: return {30'h0, ist_ff};
			`LFD_H_IRQ_MASK: return {30'h0, imask_ff};
			`LFD_H_DIV:      return {24'h0, div_ff};
			default:         return 32'h0;
		endcase
	endfunction
	// Byte on the wire for each step: address, pointer, data or read address.
	wire [7:0] tx_byte = seq_ff == 2'd0 ? {DEV_ADDR, 1'b0} :
		seq_ff == 2'd1 ? ptr_ff : seq_ff == 2'd2 ? wdat_ff :
		{DEV_ADDR, 1'b1};
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			aw_ff <= 1'b0;
			w_ff <= 1'b0;
			awa_ff <= 8'h00;
			wd_ff <= 32'h0;
			S_AXI_BVALID <= 1'b0;
			S_AXI_RVALID <= 1'b0;
			S_AXI_RDATA <= 32'h0;
			ptr_ff <= 8'h00;
			wdat_ff <= 8'h00;
			imask_ff <= 2'b00;
			div_ff <= `LFD_RST_DIV;
		end else begin
			if (aw_go) begin
				aw_ff <= 1'b1;
				awa_ff <= S_AXI_AWADDR;
			end
			if (w_go) begin
				w_ff <= 1'b1;
				wd_ff <= S_AXI_WDATA;
			end
			if (wr_do) begin
				aw_ff <= 1'b0;
				w_ff <= 1'b0;
				S_AXI_BVALID <= 1'b1;
				if (awa_ff == `LFD_H_ADDR)
					ptr_ff <= wd_ff[7:0];
				if (awa_ff == `LFD_H_WDATA)
					wdat_ff <= wd_ff[7:0];
				if (awa_ff == `LFD_H_IRQ_MASK)
					imask_ff <= wd_ff[1:0];
				if (awa_ff == `LFD_H_DIV && wd_ff[7:0] != 8'h00)
					div_ff <= wd_ff[7:0];
			end else if (S_AXI_BREADY)
				S_AXI_BVALID <= 1'b0;
			if (S_AXI_ARVALID && !S_AXI_RVALID) begin
				S_AXI_RVALID <= 1'b1;
				S_AXI_RDATA <= rd_map(S_AXI_ARADDR);
			end else if (S_AXI_RREADY)
				S_AXI_RVALID <= 1'b0;
		end
	end
	wire clr_irq = wr_do && awa_ff == `LFD_H_IRQ_STAT;
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N)
			ist_ff <= 2'b00;
		else
			ist_ff <= (ist_ff & ~(clr_irq ? wd_ff[1:0] : 2'b00)) |
				{done & nak_ff, done};
	end
	// Each bit has four phases: data set, high, sample, low.
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			st_ff <= C_IDLE;
			dcnt_ff <= 8'h00;
			ph_ff <= 2'd0;
			seq_ff <= 2'd0;
			bit_ff <= 3'd0;
			sh_ff <= 8'h00;
			rdat_ff <= 8'h00;
			rd_ff <= 1'b0;
			rx_ff <= 1'b0;
			nak_ff <= 1'b0;
			busy_ff <= 1'b0;
			restart_ff <= 1'b0;
			LINK.scl_oe <= 1'b0;
			LINK.sda_host_oe <= 1'b0;
		end else if (go) begin
			busy_ff <= 1'b1;
			rd_ff <= wd_ff[1];
			nak_ff <= 1'b0;
			seq_ff <= 2'd0;
			ph_ff <= 2'd0;
			dcnt_ff <= div_ff;
			st_ff <= C_START;
		end else if (st_ff != C_IDLE) begin
			dcnt_ff <= tick ? div_ff : dcnt_ff - 8'h01;
			if (tick) begin
				ph_ff <= ph_ff + 2'd1;
				unique case (st_ff)
					C_START: begin
						if (ph_ff == 2'd0) begin
							LINK.sda_host_oe <= 1'b0;
						end else if (ph_ff == 2'd1) begin
							LINK.scl_oe <= 1'b0;
						end else if (ph_ff == 2'd2) begin
							LINK.sda_host_oe <= 1'b1;
						end else begin
							LINK.scl_oe <= 1'b1;
							sh_ff <= tx_byte;
							bit_ff <= 3'd7;
							rx_ff <= 1'b0;
							st_ff <= C_BIT;
						end
					end
					C_BIT: begin
						if (ph_ff == 2'd0) begin
							LINK.sda_host_oe <= rx_ff ? 1'b0 : ~sh_ff[7];
						end else if (ph_ff == 2'd1) begin
							LINK.scl_oe <= 1'b0;
						end else if (ph_ff == 2'd2) begin
							sh_ff <= {sh_ff[6:0], ln[0]};
						end else begin
							LINK.scl_oe <= 1'b1;
							bit_ff <= bit_ff - 3'd1;
							if (bit_ff == 3'd0)
								st_ff <= C_ACK;
						end
					end
					C_ACK: begin
						if (ph_ff == 2'd0) begin
							LINK.sda_host_oe <= 1'b0;
							if (rx_ff)
								rdat_ff <= sh_ff;
						end else if (ph_ff == 2'd1) begin
							LINK.scl_oe <= 1'b0;
						end else if (ph_ff == 2'd2) begin
							if (!rx_ff && ln[0])
								nak_ff <= 1'b1;
						end else begin
							LINK.scl_oe <= 1'b1;
							if (nak_ff || rx_ff || seq_ff == 2'd2 ||
								(seq_ff == 2'd1 && !rd_ff)) begin
								st_ff <= C_STOP;
							end else if (seq_ff == 2'd1) begin
								seq_ff <= 2'd3;
								restart_ff <= 1'b1;
								st_ff <= C_START;
							end else if (seq_ff == 2'd3) begin
								rx_ff <= 1'b1;
								bit_ff <= 3'd7;
								st_ff <= C_BIT;
							end else begin
								seq_ff <= 2'd1;
								sh_ff <= ptr_ff;
								bit_ff <= 3'd7;
								st_ff <= C_BIT;
							end
							if (seq_ff == 2'd1 && rd_ff && !nak_ff)
								seq_ff <= 2'd3;
							else if (seq_ff == 2'd1 && !nak_ff)
								seq_ff <= 2'd2;
							if (seq_ff == 2'd1 && !rd_ff && !nak_ff) begin
								sh_ff <= wdat_ff;
								bit_ff <= 3'd7;
								st_ff <= C_BIT;
							end
						end
					end
					C_STOP: begin
						if (ph_ff == 2'd0) begin
							LINK.sda_host_oe <= 1'b1;
						end else if (ph_ff == 2'd1) begin
							LINK.scl_oe <= 1'b0;
						end else if (ph_ff == 2'd2) begin
							LINK.sda_host_oe <= 1'b0;
						end else begin
							busy_ff <= 1'b0;
							restart_ff <= 1'b0;
							st_ff <= C_IDLE;
						end
					end
					default: st_ff <= C_IDLE;
				endcase
			end
		end
	end
endmodule

// *** lfd_link_assertions.sv ***
// Checker of the two-wire link joining the controller and the target.
// Assumes both ends run on CORE_CLK and the link idles high.
`timescale 1ns/1ps
module lfd_link_assertions #(
	parameter logic [6:0] DEV_ADDR = 7'h63
) (
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic scl_oe,
	input wire logic sda_host_oe,
	input wire logic sda_dev_oe,
	input wire logic scl,
	input wire logic sda
);
	logic       scl_q, sda_q, rd_ff, sel_ff, nack_ff;
	logic [3:0] bit_ff;
	logic [1:0] byte_ff;
	logic [7:0] sh_ff;
	wire        rise = scl & ~scl_q;
	wire        edg  = scl & scl_q & (sda ^ sda_q);
	wire        stp  = edg & sda;
	wire        ack9 = rise & (bit_ff == 4'h8);
	wire        hit  = sh_ff[7:1] == DEV_ADDR;
	wire        b0   = byte_ff == 2'h0;
	wire        hbit = scl & ~rise & (bit_ff != 4'h0) & (bit_ff != 4'h9);
	always_ff @(posedge CORE_CLK) begin
		scl_q <= scl;
		sda_q <= sda;
		if (!RST_N || edg) begin
			bit_ff  <= 4'h0;
			byte_ff <= 2'h0;
			rd_ff   <= 1'b0;
			sel_ff  <= 1'b0;
			nack_ff <= 1'b0;
		end else if (rise) begin
			bit_ff <= (bit_ff == 4'h9) ? 4'h1 : bit_ff + 4'h1;
			sh_ff  <= {sh_ff[6:0], sda};
			if (bit_ff == 4'h7 && b0) rd_ff <= sda;
			if (ack9 && b0) sel_ff <= hit;
			if (ack9 && !b0 && rd_ff && sel_ff && sda) nack_ff <= 1'b1;
			if (bit_ff == 4'h9 && byte_ff != 2'h3) byte_ff <= byte_ff + 2'h1;
		end
	end
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RST_N);
	sequence ack_hold;
		sda_dev_oe [*4];
	endsequence
	sequence released;
		!sda_dev_oe [*4];
	endsequence
	a_dev_stable_high: assert property (scl && scl_q |-> $stable(sda_dev_oe))
		else $error("Target changed data while clock high.");
	a_stop_released: assert property (stp |=> released)
		else $error("Target drove data after stop.");
	a_addr_ack: assert property (ack9 && b0 && hit |-> ack_hold)
		else $error("Own address not acknowledged.");
	a_other_addr: assert property (ack9 && b0 && !hit |-> !sda_dev_oe)
		else $error("Foreign address acknowledged.");
	a_quiet_host_bits: assert property (hbit && (b0 || !rd_ff) |-> !sda_dev_oe)
		else $error("Target drove data during host bits.");
	a_data_ack: assert property (ack9 && !b0 && !rd_ff && sel_ff |-> ack_hold)
		else $error("Written byte not acknowledged.");
	a_ack_release: assert property ($fell(scl) && bit_ff == 4'h9 && !rd_ff |-> ##[1:8] !sda_dev_oe)
		else $error("Acknowledge not released.");
	a_host_ack_free: assert property (ack9 && !b0 && rd_ff |-> !sda_dev_oe)
		else $error("Target drove data in host acknowledge slot.");
	a_nack_idle: assert property (nack_ff |-> !sda_dev_oe)
		else $error("Target drove data after no acknowledge.");
endmodule

// *** lfd_tb_top.sv ***
// Testbench: controller and target share one link; a second target is
// driven bit by bit by the bench. Assumes CORE_CLK at 20 MHz.
`timescale 1ns/1ps
`include "lfd_regs.svh"
module lfd_tb_top;
	import lfd_pkg::*;
	localparam logic [6:0] DA = 7'h63;
	logic        core_clk, rst_n, irq, b_scl_oe, b_sda_oe, edge_a, i0;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [1:0]  bresp, rresp;
	logic [3:0]  wstrb;
	logic [7:0]  awaddr, araddr, f1, f2, last, q;
	logic [8:0]  r;
	logic [31:0] wdata, rdata, s;
	lfd_mode_t   mode_a;
	lfd_byte_t   fl2_a, to2_a, to2_b;
	logic [7:0]  ofs [15];
	logic [7:0]  rsv [15];
	logic [7:0]  mem [15];
	logic [7:0]  v [3];
	int          fail_count, n_checks, i;
	lfd_link_if link_a ();
	lfd_link_if link_b ();
	assign link_b.scl_oe      = b_scl_oe;
	assign link_b.sda_host_oe = b_sda_oe;
	lfd_controller #(.DEV_ADDR(DA)) lfd_controller_inst (
		.CORE_CLK(core_clk), .RST_N(rst_n), .LINK(link_a.host),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb),
		.S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp),
		.S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .IRQ(irq));
	lfd_target #(.DEV_ADDR(DA)) lfd_target_inst (
		.CORE_CLK(core_clk), .RST_N(rst_n), .LINK(link_a.dev),
		.FAULT1_SET(f1), .FAULT2_SET(f2), .LAST_LEVEL(last), .MODE(mode_a),
		.STROBE_EDGE(edge_a), .SECOND_FLASH_LEVEL(fl2_a),
		.SECOND_TORCH_LEVEL(to2_a));
	lfd_target #(.DEV_ADDR(DA)) lfd_target_inst2 (
		.CORE_CLK(core_clk), .RST_N(rst_n), .LINK(link_b.dev),
		.FAULT1_SET(f1), .FAULT2_SET(f2), .LAST_LEVEL(last), .MODE(),
		.STROBE_EDGE(), .SECOND_FLASH_LEVEL(), .SECOND_TORCH_LEVEL(to2_b));
	lfd_link_assertions #(.DEV_ADDR(DA)) lfd_link_assertions_inst (
		.CORE_CLK(core_clk), .RST_N(rst_n), .scl_oe(link_a.scl_oe),
		.sda_host_oe(link_a.sda_host_oe), .sda_dev_oe(link_a.sda_dev_oe),
		.scl(link_a.scl), .sda(link_a.sda));
	always #25 core_clk = ~core_clk;
	task automatic chk(input string nm, input logic [31:0] got, exp);
		n_checks++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic tally_and_finish();
		$display("Checks %0d, mismatches %0d.", n_checks, fail_count);
		if (fail_count == 0 && n_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	function automatic logic [6:0] follow(input logic [7:0] first, own);
		return first[7] ? first[6:0] : own[6:0];
	endfunction
	task automatic wt(input int n);
		repeat (n) @(posedge core_clk);
	endtask
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
		end while (!bvalid);
		chk("bresp", bresp, 2'b00);
		bready <= 1'b0;
	endtask
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge core_clk);
			if (arready) arvalid <= 1'b0;
		end while (!rvalid);
		d = rdata;
		rready <= 1'b0;
	endtask
	task automatic link_op(input logic rd, input logic [7:0] p, d,
			output logic [7:0] o);
		int n;
		axi_wr(`LFD_H_ADDR, {24'h0, p});
		axi_wr(`LFD_H_WDATA, {24'h0, d});
		axi_wr(`LFD_H_CTRL, {30'h0, rd, 1'b1});
		n = 0;
		do begin
			axi_rd(`LFD_H_STATUS, s);
			n++;
		end while (s[0] && n < 500);
		chk("busy", s[0], 1'b0);
		chk("nak", s[1], 1'b0);
		axi_rd(`LFD_H_RDATA, s);
		o = s[7:0];
	endtask
	task automatic tw(input logic [7:0] p, d);
		logic [7:0] o;
		link_op(1'b0, p, d, o);
	endtask
	task automatic tr(input logic [7:0] p, output logic [7:0] o);
		link_op(1'b1, p, 8'h00, o);
	endtask
	task automatic bb_bit(input logic bv, output logic sd);
		b_sda_oe <= ~bv;
		wt(4);
		b_scl_oe <= 1'b0;
		wt(6);
		sd = link_b.sda;
		b_scl_oe <= 1'b1;
		wt(2);
	endtask
	task automatic bb_byte(input logic [8:0] o, output logic [8:0] in);
		logic b;
		for (int k = 8; k >= 0; k--) begin
			bb_bit(o[k], b);
			in[k] = b;
		end
	endtask
	task automatic bb_start();
		b_sda_oe <= 1'b0;
		wt(3);
		b_scl_oe <= 1'b0;
		wt(6);
		b_sda_oe <= 1'b1;
		wt(6);
		b_scl_oe <= 1'b1;
		wt(3);
	endtask
	task automatic bb_stop();
		b_sda_oe <= 1'b1;
		wt(3);
		b_scl_oe <= 1'b0;
		wt(6);
		b_sda_oe <= 1'b0;
		wt(6);
	endtask
	task automatic bb_read3(input logic [7:0] p, output logic [7:0] o [3]);
		bb_start();
		bb_byte({DA, 2'b01}, r);
		bb_byte({p, 1'b1}, r);
		bb_start();
		bb_byte({DA, 2'b11}, r);
		chk("rd ack", r[0], 1'b0);
		for (int j = 0; j < 3; j++) begin
			bb_byte({8'hff, j == 2}, r);
			o[j] = r[8:1];
		end
		bb_byte(9'h1ff, r);
		chk("after nack", r, 9'h1ff);
		bb_stop();
	endtask
	initial begin
		repeat (90000) @(posedge core_clk);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		core_clk = 0;
		rst_n = 0;
		{awvalid, wvalid, bready, arvalid, rready, b_scl_oe, b_sda_oe} = '0;
		{awaddr, araddr, f1, f2, wdata} = '0;
		wstrb = 4'hf;
		fail_count = 0;
		n_checks = 0;
		ofs = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
			8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h39};
		rsv = '{8'h5a, 8'h80, 8'h01, 8'hbf, 8'h3f, 8'hbf, 8'h3f, 8'h09,
			8'h1a, 8'h08, 8'h00, 8'h00, 8'h21, 8'h00, 8'h7f};
		void'($urandom(94));
		last = 8'($urandom);
		repeat (5) @(posedge core_clk);
		rst_n <= 1'b1;
		axi_rd(`LFD_H_DIV, s);
		chk("div", s, 32'h5);
		axi_wr(8'h40, 32'hff);
		axi_rd(8'h40, s);
		chk("unmapped", s, 32'h0);
		axi_wr(`LFD_H_DIV, 32'h2);
		for (i = 0; i < 15; i++) begin
			tr(ofs[i], q);
			chk("reset", q, i == 13 ? last : rsv[i]);
		end
		for (i = 1; i < 15; i++) begin
			if (i > 9 && i != 14) continue;
			mem[i] = 8'($urandom) & 8'h7f;
			tw(ofs[i], mem[i]);
			tr(ofs[i], q);
			chk("rw", q, mem[i]);
		end
		tw(8'h00, 8'hff);
		tw(8'h0c, 8'h00);
		tr(8'h00, q);
		chk("chip", q, 8'h5a);
		tr(8'h0c, q);
		chk("part", q, 8'h21);
		for (i = 0; i < 4; i++) begin
			tw(8'h01, {1'b1, i[0], 2'b00, i[1:0], 2'b00});
			chk("mode", mode_a, i[1:0]);
			chk("edge", edge_a, i[0]);
		end
		for (i = 0; i < 2; i++) begin
			tw(8'h03, {i[0], 7'h55});
			chk("flash2", fl2_a[6:0], follow({i[0], 7'h55}, mem[4]));
		end
		@(posedge core_clk);
		f1 <= 8'($urandom) | 8'h01;
		f2 <= 8'($urandom) | 8'h01;
		@(posedge core_clk);
		v[0] = f1;
		v[1] = f2;
		f1 <= 8'h00;
		f2 <= 8'h00;
		for (i = 0; i < 2; i++) begin
			tr(8'h0a + i[7:0], q);
			chk("flags", q, v[i]);
			tr(8'h0a + i[7:0], q);
			chk("flags clr", q, 8'h00);
		end
		axi_rd(`LFD_H_IRQ_STAT, s);
		chk("irq stat", s[1:0], 2'b01);
		axi_wr(`LFD_H_IRQ_MASK, 32'h0);
		wt(1);
		i0 = irq;
		axi_wr(`LFD_H_IRQ_MASK, 32'h3);
		wt(1);
		chk("irq mask", i0 ^ irq, 1'b1);
		axi_wr(`LFD_H_IRQ_STAT, 32'h3);
		axi_rd(`LFD_H_IRQ_STAT, s);
		chk("irq clr", s[1:0], 2'b00);
		chk("irq low", irq, 1'b0);
		bb_start();
		bb_byte({DA ^ 7'h01, 2'b01}, r);
		chk("foreign", r[0], 1'b1);
		bb_stop();
		bb_start();
		bb_byte({DA, 2'b01}, r);
		bb_byte({8'h05, 1'b1}, r);
		for (i = 0; i < 3; i++) begin
			v[i] = 8'($urandom) & 8'h7f;
			bb_byte({v[i], 1'b1}, r);
			chk("wr ack", r[0], 1'b0);
		end
		bb_stop();
		chk("torch2", to2_b[6:0], follow(v[0], v[1]));
		bb_read3(8'h05, mem[0:2]);
		for (i = 0; i < 3; i++)
			chk("burst", mem[i], v[i]);
		bb_start();
		bb_byte({DA, 2'b01}, r);
		bb_byte({8'h08, 1'b1}, r);
		for (i = 0; i < 4; i++)
			bb_bit(1'b1, r[0]);
		b_sda_oe <= 1'b1;
		wt(3);
		b_scl_oe <= 1'b0;
		wt(3);
		b_sda_oe <= 1'b0;
		wt(3);
		b_scl_oe <= 1'b1;
		wt(3);
		bb_byte(9'h001, r);
		chk("abort", r[0], 1'b1);
		bb_stop();
		bb_read3(8'h08, mem[0:2]);
		chk("abort kept", mem[0], 8'h1a);
		tally_and_finish();
	end
endmodule
